// ==== pdf_defines.svh ====
// Constants for the peripheral debug freeze register bank.
// Assumes inclusion by the package and the design module only.
`ifndef PDF_DEFINES_SVH
`define PDF_DEFINES_SVH
`define PDF_CTRL_ADDR     32'hE0042000
`define PDF_CTRL_RESET    32'h00000000
`define PDF_WATCHDOG_BIT  0
`define PDF_TIMER_BIT     1
`define PDF_EVENT_BIT     2
`define PDF_CTRL_WIDTH    3
`define PDF_RDATA_IDLE    32'h00000000
`endif

// ==== pdf_far_model.sv ====
// Far-side model: the core debug logic that raises and drops the halt level.
// Assumes the bench requests halts and the halt leaves on a clock edge.
`timescale 1ns/100ps
module pdf_far_model (
   input  wire logic core_clk,       // System clock.
   input  wire logic halt_req,       // Halt request from the bench.
   output logic      core_debug_halt // Halt level, registered like real debug logic.
);
   always_ff @(posedge core_clk) core_debug_halt <= halt_req;
endmodule : pdf_far_model

// ==== pdf_freeze.sv ====
// Peripheral debug freeze control register and freeze qualifiers.
// Assumes a same-clock register master and a debug halt level from the core's debug logic.
//
// Summary of operation
// - With the watchdog freeze bit (bit 0) set and the core halted, the watchdog counter is held.
// - With the watchdog freeze bit clear, the watchdog counter runs even while the core is halted.
// - With the timer freeze bit (bit 1) set and the core halted, the timer prescaler and counter stop.
// - With the timer freeze bit clear, the timer prescaler and counter keep running in debug.
// - With the event freeze bit (bit 2) set and the core halted, the event controller is frozen.
// - With the event freeze bit clear, the event controller runs normally in debug.
// - The control register is read/write, resets to zero, and bits 31 to 3 are reserved.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`include "pdf_defines.svh"

module pdf_freeze (
   input  wire logic               core_clk,           // System clock, 250 MHz.
   input  wire logic               sys_rst,            // Asynchronous reset, active high.
   input  wire pdf_pkg::pdf_word_t reg_addr,           // Register byte address.
   input  wire pdf_pkg::pdf_word_t reg_wdata,          // Write data.
   input  wire logic               reg_wr,             // Write strobe.
   input  wire logic               reg_rd,             // Read strobe.
   output pdf_pkg::pdf_word_t      reg_rdata,          // Read data, valid the cycle after the strobe.
   input  wire logic               core_debug_halt,    // Core halted in debug, same clock domain.
   output logic                    watchdog_freeze,    // Hold the watchdog counter.
   output logic                    async_timer_freeze, // Stop timer prescaler and counter.
   output logic                    event_system_freeze // Freeze the event controller.
);
   import pdf_pkg::*;

   // True when a bus address selects the control register; every other address falls through.
   function automatic logic hits_ctrl(input pdf_word_t addr);
      return addr == `PDF_CTRL_ADDR;
   endfunction : hits_ctrl

   // Widens the stored bits to a bus word, so reserved positions always read as zero.
   function automatic pdf_word_t ctrl_word(input pdf_ctrl_t ctrl);
      return pdf_word_t'(ctrl);
   endfunction : ctrl_word

   // A qualifier is raised only while its enable bit and the halt level are both high.
   function automatic logic freeze_qual(input pdf_ctrl_t ctrl, input int unsigned pos, input logic halt);
      return ctrl[pos] && halt;
   endfunction : freeze_qual

   pdf_ctrl_t ctrl_reg;
   pdf_ctrl_t ctrl_next;
   pdf_ctrl_t wdata_field;
   pdf_word_t rdata_next;
   logic      watchdog_next;
   logic      timer_next;
   logic      event_next;
   logic      ctrl_wr_hit;
   logic      ctrl_rd_hit;

   assign ctrl_wr_hit = reg_wr && hits_ctrl(reg_addr);
   assign ctrl_rd_hit = reg_rd && hits_ctrl(reg_addr);
   // Only the defined bits are stored, so writes to reserved bits have nothing to land in.
   assign wdata_field = reg_wdata[`PDF_CTRL_WIDTH-1:0];
   assign ctrl_next   = ctrl_wr_hit ? wdata_field : ctrl_reg;
   // Read data is zero outside the answer cycle and for unmapped addresses.
   assign rdata_next  = ctrl_rd_hit ? ctrl_word(ctrl_reg) : `PDF_RDATA_IDLE;
   // The qualifiers drop one edge after the halt drops, so peripherals resume from their held state.
   assign watchdog_next = freeze_qual(ctrl_reg, `PDF_WATCHDOG_BIT, core_debug_halt);
   assign timer_next    = freeze_qual(ctrl_reg, `PDF_TIMER_BIT, core_debug_halt);
   assign event_next    = freeze_qual(ctrl_reg, `PDF_EVENT_BIT, core_debug_halt);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg <= pdf_ctrl_t'(`PDF_CTRL_RESET);
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= `PDF_RDATA_IDLE;
      end else begin
         reg_rdata <= rdata_next;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         watchdog_freeze <= 1'b0;
      end else begin
         watchdog_freeze <= watchdog_next;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         async_timer_freeze <= 1'b0;
      end else begin
         async_timer_freeze <= timer_next;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         event_system_freeze <= 1'b0;
      end else begin
         event_system_freeze <= event_next;
      end
   end

   a_watchdog_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
      1'b1
      |=> watchdog_freeze == ($past(ctrl_reg[`PDF_WATCHDOG_BIT]) && $past(core_debug_halt)))
      else $error("watchdog freeze does not follow its bit and the halt");

   a_watchdog_set: assert property (@(posedge core_clk) disable iff (sys_rst)
      (ctrl_reg[`PDF_WATCHDOG_BIT] && core_debug_halt)
      |=> watchdog_freeze)
      else $error("watchdog not frozen while halted");

   a_watchdog_free: assert property (@(posedge core_clk) disable iff (sys_rst)
      !ctrl_reg[`PDF_WATCHDOG_BIT]
      |=> !watchdog_freeze)
      else $error("watchdog frozen with its bit clear");

   a_watchdog_halted_free: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!ctrl_reg[`PDF_WATCHDOG_BIT] && core_debug_halt)
      |=> !watchdog_freeze)
      else $error("watchdog frozen in halt with its bit clear");

   a_timer_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
      1'b1
      |=> async_timer_freeze == ($past(ctrl_reg[`PDF_TIMER_BIT]) && $past(core_debug_halt)))
      else $error("timer freeze does not follow its bit and the halt");

   a_timer_set: assert property (@(posedge core_clk) disable iff (sys_rst)
      (ctrl_reg[`PDF_TIMER_BIT] && core_debug_halt)
      |=> async_timer_freeze)
      else $error("timer not frozen while halted");

   a_timer_free: assert property (@(posedge core_clk) disable iff (sys_rst)
      !ctrl_reg[`PDF_TIMER_BIT]
      |=> !async_timer_freeze)
      else $error("timer frozen with its bit clear");

   a_timer_halted_free: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!ctrl_reg[`PDF_TIMER_BIT] && core_debug_halt)
      |=> !async_timer_freeze)
      else $error("timer frozen in halt with its bit clear");

   a_event_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
      1'b1
      |=> event_system_freeze == ($past(ctrl_reg[`PDF_EVENT_BIT]) && $past(core_debug_halt)))
      else $error("event freeze does not follow its bit and the halt");

   a_event_set: assert property (@(posedge core_clk) disable iff (sys_rst)
      (ctrl_reg[`PDF_EVENT_BIT] && core_debug_halt)
      |=> event_system_freeze)
      else $error("event controller not frozen while halted");

   a_event_free: assert property (@(posedge core_clk) disable iff (sys_rst)
      !ctrl_reg[`PDF_EVENT_BIT]
      |=> !event_system_freeze)
      else $error("event controller frozen with its bit clear");

   a_event_halted_free: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!ctrl_reg[`PDF_EVENT_BIT] && core_debug_halt)
      |=> !event_system_freeze)
      else $error("event controller frozen in halt with its bit clear");

   a_ctrl_write: assert property (@(posedge core_clk) disable iff (sys_rst)
      ctrl_wr_hit
      |=> ctrl_reg == $past(reg_wdata[`PDF_CTRL_WIDTH-1:0]))
      else $error("control register did not take the write");

   a_ctrl_readback: assert property (@(posedge core_clk) disable iff (sys_rst)
      ctrl_wr_hit ##1 ctrl_rd_hit
      |=> reg_rdata == ctrl_word($past(reg_wdata[`PDF_CTRL_WIDTH-1:0], 2)))
      else $error("control register read back wrong");

   a_read_data: assert property (@(posedge core_clk) disable iff (sys_rst)
      ctrl_rd_hit
      |=> reg_rdata == ctrl_word($past(ctrl_reg)))
      else $error("read data does not match the control register");

   a_ctrl_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      !ctrl_wr_hit
      |=> $stable(ctrl_reg))
      else $error("control register changed without a write to it");

   a_read_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
      !ctrl_rd_hit
      |=> reg_rdata == `PDF_RDATA_IDLE)
      else $error("read data not zero outside the answer cycle");

   a_reserved_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      1'b1
      |-> reg_rdata[31:`PDF_CTRL_WIDTH] == '0)
      else $error("reserved bits read nonzero");

   a_resume_on_exit: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(core_debug_halt)
      |=> !watchdog_freeze && !async_timer_freeze && !event_system_freeze)
      else $error("peripheral still frozen after halt ended");

   a_watchdog_resume: assert property (@(posedge core_clk) disable iff (sys_rst)
      (watchdog_freeze && !core_debug_halt)
      |=> !watchdog_freeze)
      else $error("watchdog still frozen after halt ended");

   a_timer_resume: assert property (@(posedge core_clk) disable iff (sys_rst)
      (async_timer_freeze && !core_debug_halt)
      |=> !async_timer_freeze)
      else $error("timer still frozen after halt ended");

   a_event_resume: assert property (@(posedge core_clk) disable iff (sys_rst)
      (event_system_freeze && !core_debug_halt)
      |=> !event_system_freeze)
      else $error("event controller still frozen after halt ended");

   a_no_halt_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
      !core_debug_halt
      |=> !watchdog_freeze && !async_timer_freeze && !event_system_freeze)
      else $error("peripheral frozen while the core runs");

endmodule : pdf_freeze

// ==== pdf_freeze_tb_top.sv ====
// Self-checking bench for the debug freeze register and its freeze outputs.
// Assumes a one-cycle register bus and the registered freeze outputs.
`timescale 1ns/100ps
module pdf_freeze_tb_top;
   import pdf_pkg::*;
   logic        core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, halt_req = 1'b0, core_debug_halt;
   logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata, d;
   logic [2:0]  frz;
   int          err_total = 0, n_compared = 0, seed = 26;
   always #2 core_clk = ~core_clk;
   pdf_freeze DUT (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_debug_halt(core_debug_halt),
      .watchdog_freeze(frz[0]), .async_timer_freeze(frz[1]), .event_system_freeze(frz[2]));
   pdf_far_model FAR (.core_clk(core_clk), .halt_req(halt_req), .core_debug_halt(core_debug_halt));
   function automatic logic [31:0] exp_frz(input logic [31:0] c, input logic h);
      return {29'h0, c[2:0] & {3{h}}};
   endfunction : exp_frz
   task automatic bad(input logic [31:0] got, input logic [31:0] exp);
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
   endtask : bad
   task automatic cmp_rd(input logic [31:0] exp);
      n_compared++;
      if (reg_rdata !== exp) bad(reg_rdata, exp);
   endtask : cmp_rd
   task automatic cmp_frz(input logic [31:0] exp);
      n_compared++;
      if ({29'h0, frz} !== exp) bad({29'h0, frz}, exp);
   endtask : cmp_frz
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 cmp_rd(e);
      @(posedge core_clk);
      #1 cmp_rd(32'h0);
      @(posedge core_clk);
   endtask : rd
   task automatic halt(input logic h, input logic [31:0] c);
      halt_req <= h;
      repeat (3) @(posedge core_clk);
      #1 cmp_frz(exp_frz(c, h));
      @(posedge core_clk);
   endtask : halt
   task automatic complete_run;
      if (err_total == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   initial begin
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      rd(32'hE0042000, 32'h0);
      for (int i = 0; i < 8; i++) begin
         d = $random(seed);
         d[2:0] = i[2:0];
         wr(32'hE0042000, d);
         rd(32'hE0042000, {29'h0, d[2:0]});
         wr(32'hE0042004, ~d);
         rd(32'hE0042004, 32'h0);
         rd(32'hE0042000, {29'h0, d[2:0]});
         halt(1'b1, d);
         halt(1'b0, d);
      end
      wr(32'hE0042000, 32'h7);
      halt(1'b1, 32'h7);
      sys_rst <= 1'b1;
      halt_req <= 1'b0;
      @(posedge core_clk);
      #1 cmp_frz(32'h0);
      @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      rd(32'hE0042000, 32'h0);
      halt(1'b1, 32'h0);
      complete_run();
   end
   initial begin
      #20000 err_total++;
      complete_run();
   end
endmodule : pdf_freeze_tb_top

// ==== pdf_pkg.sv ====
// Types shared by the peripheral debug freeze block.
// Assumes the defines header is on the include path.
`include "pdf_defines.svh"
package pdf_pkg;
   typedef logic [31:0] pdf_word_t;
   typedef logic [`PDF_CTRL_WIDTH-1:0] pdf_ctrl_t;
endpackage : pdf_pkg
